// [hdl/result_bank_pkg.sv]
package result_bank_pkg;

   // conversion result geometry
   localparam int RESULT_W  = 12;          // bits per conversion result
   localparam int CHAN_NUM  = 6;           // cell4, cell5, cell6, cell7, sensor1, sensor2
   localparam int CHAN_W    = 3;           // width of a channel index
   localparam int ADDR_W    = 8;           // register address width
   localparam int DATA_W    = 8;           // register data width

   // channel indices into the result store
   localparam logic [CHAN_W-1:0] CHAN_CELL4   = 3'h0;
   localparam logic [CHAN_W-1:0] CHAN_CELL5   = 3'h1;
   localparam logic [CHAN_W-1:0] CHAN_CELL6   = 3'h2;
   localparam logic [CHAN_W-1:0] CHAN_CELL7   = 3'h3;
   localparam logic [CHAN_W-1:0] CHAN_SENSOR1 = 3'h4;
   localparam logic [CHAN_W-1:0] CHAN_SENSOR2 = 3'h5;

   // register offsets
   localparam logic [ADDR_W-1:0] CELL4_RESULT_HIGH   = 8'h0E;
   localparam logic [ADDR_W-1:0] CELL5_RESULT_LOW    = 8'h0F;
   localparam logic [ADDR_W-1:0] CELL5_RESULT_HIGH   = 8'h10;
   localparam logic [ADDR_W-1:0] CELL6_RESULT_LOW    = 8'h11;
   localparam logic [ADDR_W-1:0] CELL6_RESULT_HIGH   = 8'h12;
   localparam logic [ADDR_W-1:0] CELL7_RESULT_LOW    = 8'h13;
   localparam logic [ADDR_W-1:0] CELL7_RESULT_HIGH   = 8'h14;
   localparam logic [ADDR_W-1:0] SENSOR1_RESULT_LOW  = 8'h15;
   localparam logic [ADDR_W-1:0] SENSOR1_RESULT_HIGH = 8'h16;
   localparam logic [ADDR_W-1:0] SENSOR2_RESULT_LOW  = 8'h17;
   localparam logic [ADDR_W-1:0] SENSOR2_RESULT_HIGH = 8'h18;

   // bank limits; the bank starts one below a pair boundary (cell4 low lives elsewhere)
   localparam logic [ADDR_W-1:0] BANK_BASE = 8'h0D;    // virtual slot of cell4 low
   localparam logic [ADDR_W-1:0] BANK_LAST = SENSOR2_RESULT_HIGH;

   // field layout
   localparam int LOW_MSB  = 7;            // low register carries result bits 7..0
   localparam int HIGH_LSB = 8;            // high register carries result bits 11..8
   localparam int HIGH_W   = 4;            // high register field width, bits 7..4 reserved

   // reset values
   localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
   localparam logic [DATA_W-1:0]   DATA_RESET   = 8'h00;

   // result load from the conversion engine
   typedef struct packed {
      logic [CHAN_W-1:0]   chan;           // which result
      logic [RESULT_W-1:0] value;          // 12-bit conversion code
   } result_load_type;

   // host register access
   typedef struct packed {
      logic              rd;               // read strobe
      logic              wr;               // write strobe
      logic [ADDR_W-1:0] addr;             // register offset
      logic [DATA_W-1:0] wdata;            // write data, never stored
   } reg_req_type;

endpackage

// [hdl/result_store.sv]
`timescale 1ns/1ps
module result_store
   import result_bank_pkg::*;
(
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   // write side from the conversion engine
   input  wire logic                we_i,
   input  wire logic [CHAN_W-1:0]   wchan_i,
   input  wire logic [RESULT_W-1:0] wvalue_i,
   // read side
   input  wire logic                re_i,
   input  wire logic [CHAN_W-1:0]   rchan_i,
   output logic      [RESULT_W-1:0] rvalue_o
);

   logic [RESULT_W-1:0] mem_r [CHAN_NUM];   // one word per result channel

   // one storage word per channel; codes above the last channel are dropped
   for (genvar g = 0; g < CHAN_NUM; g++) begin : g_word
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            mem_r[g] <= RESULT_RESET;
         end else if (we_i && (wchan_i == CHAN_W'(g))) begin
            mem_r[g] <= wvalue_i;
         end
      end
   end

   // registered read; a load in the same cycle is seen on the next read only
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rvalue_o <= RESULT_RESET;
      end else if (re_i) begin
         rvalue_o <= (rchan_i < CHAN_W'(CHAN_NUM)) ? mem_r[rchan_i] : RESULT_RESET;
      end
   end

endmodule

// [hdl/cell_temp_result_registers.sv]
`timescale 1ns/1ps
module cell_temp_result_registers
   import result_bank_pkg::*;
(
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_i,          // logic supply power-on reset
   // conversion engine result load
   input  wire logic                load_i,
   input  wire result_load_type     load_data_i,
   // host register port (from either serial port front end)
   input  wire reg_req_type         req_i,
   // read answer
   output logic                     rd_valid_o,
   output logic                     rd_hit_o,
   output logic      [DATA_W-1:0]   rdata_o,
   // write answer
   output logic                     wr_ack_o
);

   logic [ADDR_W-1:0]   slot;          // offset relative to the bank base
   logic                in_bank;       // address falls inside this bank
   logic [CHAN_W-1:0]   rd_chan;       // channel addressed by the read
   logic [RESULT_W-1:0] store_value;   // registered word from the store
   logic                rd_d1_r;       // read in flight, store stage
   logic                high_d1_r;     // the read targets a high register
   logic                hit_d1_r;      // the read hit the bank
   logic [DATA_W-1:0]   byte_nxt;      // byte to present

   // decode: pairs are laid out low then high, channel = slot / 2
   always_comb begin
      slot    = req_i.addr - BANK_BASE;
      in_bank = (req_i.addr > BANK_BASE) && (req_i.addr <= BANK_LAST);
      rd_chan = slot[CHAN_W:1];        // cell7 low at 0x13, sensors after it
   end

   // result words live in a small store; host writes never reach it
   result_store i_result_store (
      .clk_i    (clk_i),
      .reset_i  (reset_i),
      .we_i     (load_i),              // only the conversion engine writes
      .wchan_i  (load_data_i.chan),
      .wvalue_i (load_data_i.value),
      .re_i     (req_i.rd && in_bank),
      .rchan_i  (rd_chan),
      .rvalue_o (store_value)
   );

   // carry the read's decode alongside the store access
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_d1_r   <= 1'b0;
         high_d1_r <= 1'b0;
         hit_d1_r  <= 1'b0;
      end else begin
         rd_d1_r   <= req_i.rd;
         high_d1_r <= slot[0];         // odd slot is the high half
         hit_d1_r  <= in_bank;
      end
   end

   // byte select; reserved bits and unmapped offsets read as zero
   always_comb begin
      byte_nxt = DATA_RESET;
      if (hit_d1_r) begin
         if (high_d1_r) begin
            byte_nxt[HIGH_W-1:0] = store_value[HIGH_LSB +: HIGH_W];
         end else begin
            byte_nxt = store_value[LOW_MSB:0];
         end
      end
   end

   // read answer register; outputs come straight from flops
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_valid_o <= 1'b0;
         rd_hit_o   <= 1'b0;
         rdata_o    <= DATA_RESET;
      end else begin
         rd_valid_o <= rd_d1_r;
         rd_hit_o   <= rd_d1_r && hit_d1_r;
         if (rd_d1_r) begin
            rdata_o <= byte_nxt;
         end
      end
   end

   // writes are acknowledged and dropped, so a front end never hangs
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ack_o <= 1'b0;
      end else begin
         wr_ack_o <= req_i.wr;         // data discarded
      end
   end

   // assertions guarding the store path, the decode and the byte split
   // a load followed at once by reads of its pair exercises all three together;
   // the bench makes that pattern on purpose, so these are not left vacuous

   // full twelve bits of cell5 come back over its two registers
   a_cell5_full_result: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (load_i && load_data_i.chan == CHAN_CELL5)
      ##1 (!load_i && req_i.rd && req_i.addr == CELL5_RESULT_HIGH)
      ##1 (!load_i && req_i.rd && req_i.addr == CELL5_RESULT_LOW)
      |-> ##1 (rd_valid_o && rdata_o == {4'h0, $past(load_data_i.value[11:8], 3)})
      ##1 (rd_valid_o && rdata_o == $past(load_data_i.value[7:0], 4)))
      else $error("cell5 result not returned across its pair");

   // low register returns bits 7..0
   a_low_byte_map: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (load_i && load_data_i.chan == CHAN_CELL6)
      ##1 (!load_i && req_i.rd && req_i.addr == CELL6_RESULT_LOW)
      |-> ##2 (rd_valid_o && rd_hit_o && rdata_o == $past(load_data_i.value[7:0], 3)))
      else $error("low register does not carry result bits 7..0");

   // high register upper nibble always reads zero
   a_high_reserved_zero: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (req_i.rd && in_bank && slot[0]) |-> ##2 (rd_valid_o && rdata_o[7:4] == 4'h0))
      else $error("reserved high nibble not zero");

   // first sensor pair holds its own result
   a_sensor1_pair: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (load_i && load_data_i.chan == CHAN_SENSOR1)
      ##1 (!load_i && req_i.rd && req_i.addr == SENSOR1_RESULT_HIGH)
      |-> ##2 (rdata_o == {4'h0, $past(load_data_i.value[11:8], 3)}))
      else $error("sensor1 high register wrong");

   // second sensor pair holds its own result
   a_sensor2_pair: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (load_i && load_data_i.chan == CHAN_SENSOR2)
      ##1 (!load_i && req_i.rd && req_i.addr == SENSOR2_RESULT_LOW)
      |-> ##2 (rdata_o == $past(load_data_i.value[7:0], 3)))
      else $error("sensor2 low register wrong");

   // cell7 low register is its own location
   a_cell7_low_own: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (load_i && load_data_i.chan == CHAN_CELL7)
      ##1 (!load_i && req_i.rd && req_i.addr == CELL7_RESULT_LOW)
      |-> ##2 (rd_hit_o && rdata_o == $past(load_data_i.value[7:0], 3)))
      else $error("cell7 low register wrong");

   // a write between two reads of one register changes nothing
   a_write_no_effect: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (!load_i && req_i.rd && in_bank)
      ##1 (!load_i && req_i.wr && !req_i.rd)
      ##1 (!load_i && req_i.rd && req_i.addr == $past(req_i.addr, 2))
      |-> ##2 (rdata_o == $past(rdata_o, 2)))
      else $error("host write altered a result");

   // write acknowledged exactly one cycle later
   a_write_ack: assert property (
      @(posedge clk_i) disable iff (reset_i)
      req_i.wr |=> wr_ack_o)
      else $error("write not acknowledged");

   // write answer only ever follows a write
   a_ack_needs_write: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_ack_o |-> $past(req_i.wr))
      else $error("write answer without a write");

   // every read is answered exactly two cycles after it is taken
   a_read_latency: assert property (
      @(posedge clk_i) disable iff (reset_i)
      req_i.rd |-> ##2 rd_valid_o)
      else $error("read answer missing two cycles after the read");

   // no answer appears without a read two cycles before it
   a_valid_needs_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      rd_valid_o |-> $past(req_i.rd, 2))
      else $error("read answer without a read");

   // the mapped span answers with the hit flag set
   a_hit_in_span: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (req_i.rd && req_i.addr >= CELL4_RESULT_HIGH && req_i.addr <= SENSOR2_RESULT_HIGH)
      |-> ##2 (rd_valid_o && rd_hit_o))
      else $error("mapped read answered without hit");

   // the hit flag is only raised for a read of the mapped span
   a_hit_needs_span: assert property (
      @(posedge clk_i) disable iff (reset_i)
      rd_hit_o
      |-> $past(req_i.addr >= CELL4_RESULT_HIGH && req_i.addr <= SENSOR2_RESULT_HIGH, 2))
      else $error("hit flag for an unmapped read");

   // offsets outside the span read zero without hit; cell4 low lives elsewhere
   a_unmapped_zero: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (req_i.rd && (req_i.addr < CELL4_RESULT_HIGH || req_i.addr > SENSOR2_RESULT_HIGH))
      |-> ##2 (rd_valid_o && !rd_hit_o && rdata_o == DATA_RESET))
      else $error("unmapped read not answered with zero");

   // hit flag only travels with an answer
   a_hit_with_valid: assert property (
      @(posedge clk_i) disable iff (reset_i)
      rd_hit_o |-> rd_valid_o)
      else $error("hit flag without an answer");

   // read byte holds between answers; the guard skips the edge right after reset
   a_rdata_holds: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (!rd_valid_o && !$past(reset_i)) |-> $stable(rdata_o))
      else $error("read byte changed without an answer");

   // all answers leave reset cleared
   a_reset_clears: assert property (
      @(posedge clk_i)
      $fell(reset_i) |-> (!rd_valid_o && !rd_hit_o && !wr_ack_o && rdata_o == DATA_RESET))
      else $error("outputs not cleared by reset");

endmodule

// [tb/host_model.sv]
`timescale 1ns/1ps
module host_model
   import result_bank_pkg::*;
(
   // clock and answers from the bank
   input  wire logic              clk_i,
   input  wire logic              rd_valid_i,
   input  wire logic              rd_hit_i,
   input  wire logic [DATA_W-1:0] rdata_i,
   input  wire logic              wr_ack_i,
   // request towards the bank
   output reg_req_type            req_o
);
   // idle port: no strobe at time zero
   initial req_o = '0;

   // one read, strobe for one edge, bounded wait for the answer
   task automatic rd(input  logic [ADDR_W-1:0] a,
                     output logic [DATA_W-1:0] d,
                     output logic              h,
                     output int                n);
      @(posedge clk_i) #1;
      req_o.addr = a;
      req_o.rd   = 1'b1;
      @(posedge clk_i) #1;
      req_o.rd   = 1'b0;
      req_o.addr = ~a;                       // released lines must not keep the last value
      for (n = 0; n < 4 && rd_valid_i !== 1'b1; n++) @(posedge clk_i) #1;
      d = rdata_i;
      h = rd_hit_i;
   endtask

   // one write; the data should never land in a result
   task automatic wr(input  logic [ADDR_W-1:0] a,
                     input  logic [DATA_W-1:0] d,
                     output logic              k);
      int n;
      @(posedge clk_i) #1;
      req_o.addr  = a;
      req_o.wdata = d;
      req_o.wr    = 1'b1;
      @(posedge clk_i) #1;
      req_o.wr    = 1'b0;
      req_o.addr  = ~a;
      req_o.wdata = ~d;
      for (n = 0; n < 3 && wr_ack_i !== 1'b1; n++) @(posedge clk_i) #1;
      k = wr_ack_i;
   endtask

   // two reads in flight at once; with gap set, a write to the first address sits between
   task automatic rd_pair(input  logic [ADDR_W-1:0] a,
                          input  logic [ADDR_W-1:0] b,
                          input  logic              gap,
                          input  logic [DATA_W-1:0] wd,
                          output logic [DATA_W-1:0] da,
                          output logic [DATA_W-1:0] db,
                          output logic              v);
      @(posedge clk_i) #1;
      req_o.addr = a;
      req_o.rd   = 1'b1;
      @(posedge clk_i) #1;
      if (gap) begin
         req_o.rd    = 1'b0;
         req_o.wr    = 1'b1;
         req_o.wdata = wd;
         @(posedge clk_i) #1;
         da          = rdata_i;
         v           = rd_valid_i & wr_ack_i;
         req_o.wr    = 1'b0;
         req_o.wdata = ~wd;
         req_o.addr  = b;
         req_o.rd    = 1'b1;
         @(posedge clk_i) #1;
      end else begin
         req_o.addr = b;
         @(posedge clk_i) #1;
         da = rdata_i;
         v  = rd_valid_i;
      end
      req_o.rd   = 1'b0;
      req_o.addr = ~b;
      @(posedge clk_i) #1;
      db = rdata_i;
      v  = v & rd_valid_i;
   endtask
endmodule

// [tb/tb_cell_temp_result_registers.sv]
`timescale 1ns/1ps
module tb_cell_temp_result_registers
   import result_bank_pkg::*;
;
   logic                clk_i       = 1'b0;
   logic                reset_i     = 1'b1;
   logic                load_i      = 1'b0;
   result_load_type     load_data_i = '0;
   reg_req_type         req_i;
   logic                rd_valid_o;
   logic                rd_hit_o;
   logic                wr_ack_o;
   logic [DATA_W-1:0]   rdata_o;
   logic [RESULT_W-1:0] m [CHAN_NUM];        // results the bank should hold
   logic [31:0]         rng = 32'h0000C26B;  // fixed seed
   int                  n_errors = 0;
   int                  checked = 0;

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   cell_temp_result_registers i_cell_temp_result_registers (
      .clk_i(clk_i), .reset_i(reset_i), .load_i(load_i), .load_data_i(load_data_i),
      .req_i(req_i), .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o), .rdata_o(rdata_o),
      .wr_ack_o(wr_ack_o));
   host_model i_host_model (
      .clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_hit_i(rd_hit_o), .rdata_i(rdata_o),
      .wr_ack_i(wr_ack_o), .req_o(req_i));

   // xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // true for the mapped span of the bank
   function automatic logic hit_of(input logic [ADDR_W-1:0] a);
      return a >= CELL4_RESULT_HIGH && a <= SENSOR2_RESULT_HIGH;
   endfunction

   // expected byte: odd slot is high nibble, even slot is low byte
   function automatic logic [DATA_W-1:0] byte_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] k;
      k = a - 8'h0D;
      if (!hit_of(a)) return 8'h00;
      if (k[0]) return {4'h0, m[k[3:1]][11:8]};
      return m[k[3:1]][7:0];
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         n_errors++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic test_done();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // read every slot from two below to two above the bank
   task automatic scan();
      logic [DATA_W-1:0] d;
      logic              h;
      int                lat;
      for (int a = 8'h0C; a <= 8'h1A; a++) begin
         i_host_model.rd(a[7:0], d, h, lat);
         chk(d, byte_of(a[7:0]));
         chk({7'h0, h}, {7'h0, hit_of(a[7:0])});
         chk(8'(lat), 8'h01);
      end
   endtask

   // load one channel and read its pair at once; the second pass reads one register twice with a write between
   task automatic pair_corner();
      logic [DATA_W-1:0] d1;
      logic [DATA_W-1:0] d2;
      logic              v;
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] a1;
      logic [ADDR_W-1:0] a2;
      for (int g = 0; g < 2; g++) begin
         for (int c = 0; c < CHAN_NUM; c++) begin
            rng = xs(rng);
            lo  = BANK_BASE + 8'(2 * c);
            a1  = (c == CHAN_CELL5 || c == CHAN_SENSOR1) ? lo + 8'h01 : lo;
            a2  = (g == 1) ? a1 : ((a1 == lo) ? lo + 8'h01 : lo);
            load_data_i = {c[2:0], rng[11:0]};
            m[c]        = rng[11:0];
            load_i      = 1'b1;
            fork
               begin
                  @(posedge clk_i) #1;
                  load_i = 1'b0;
               end
               i_host_model.rd_pair(a1, a2, g[0], rng[23:16], d1, d2, v);
            join
            chk(d1, byte_of(a1));
            chk(d2, byte_of(a2));
            chk({7'h0, v}, 8'h01);
         end
      end
   endtask

   // main sequence: reset values, loads, ignored writes, mid-run reset
   initial begin
      logic ack;
      repeat (16) @(posedge clk_i);
      #1 reset_i = 1'b0;
      foreach (m[i]) m[i] = RESULT_RESET;
      scan();
      for (int r = 0; r < 4; r++) begin
         load_i = 1'b1;                           // back-to-back loads, chan 6 and 7 too
         for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            load_data_i = {c[2:0], (r == 0) ? 12'hFFF : rng[11:0]};
            if (c < CHAN_NUM) m[c] = load_data_i.value;
            @(posedge clk_i) #1;
         end
         load_i = 1'b0;
         for (int w = 8'h0C; w <= 8'h1A; w++) begin
            rng = xs(rng);
            i_host_model.wr(w[7:0], rng[7:0], ack);
            chk({7'h0, ack}, 8'h01);
         end
         scan();
      end
      pair_corner();
      reset_i = 1'b1;
      repeat (2) @(posedge clk_i) #1;
      reset_i = 1'b0;
      foreach (m[i]) m[i] = RESULT_RESET;
      scan();
      test_done();
   end

   // watchdog at 20000 cycles, well beyond the few hundred cycles the run needs
   initial begin
      #(25 * 20000);
      n_errors++;
      test_done();
   end
endmodule
